//--- src/aps_power_sequencer.v
`include "aps_regs.vh"

// ==========================================================
// low-power modes and converter start-up timer
module aps_power_sequencer
(
    // clock and reset
    input  wire                       clk_sys,
    input  wire                       rst_n,
    // serial command side, data held stable around each toggle
    input  wire                       spiCmdToggle,
    input  wire                       spiCmdIsFast,
    input  wire [3:0]                 spiFastCode,
    input  wire [`APS_CFG_WIDTH-1:0]  spiCfgData,
    // scan sequencer side, same clock
    input  wire [1:0]                 conversionRepeatMode,
    input  wire [23:0]                scanDelay,
    input  wire                       scanCycleDone,
    // configuration and power controls
    output reg  [`APS_CFG_WIDTH-1:0]  mainConfigReg_ff,
    output reg                        fullShutdown_ff,
    output reg                        partialShutdown_ff,
    output reg                        supplyMonitorEn_ff,
    output reg                        biasEn_ff,
    output reg                        fullResetPulse_ff,
    // converter state and timer
    output reg  [3:0]                 adcState_ff,
    output reg  [8:0]                 startupTimer_ff,
    output reg                        dmclkTick_ff,
    output reg                        scanNextCycle_ff
);

    // ==========================================================
    // command arrival from the serial domain
    wire       cmdLevel;
    reg        cmdLevelD_ff;
    wire       cmdEvent;

    aps_sync3 u_cmdSync
    (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .asyncIn    (spiCmdToggle),
        .syncOut_ff (cmdLevel)
    );

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cmdLevelD_ff <= 1'b0;
        else
            cmdLevelD_ff <= cmdLevel;
    end

    // each toggle of the serial side is one command
    assign cmdEvent = cmdLevel ^ cmdLevelD_ff;

    // ==========================================================
    // command decode
    reg        isModeCmd;
    reg  [1:0] cmdMode;
    wire       isFullShdn;
    wire       isFullReset;
    wire       isCfgWrite;

    assign isFullShdn  = cmdEvent & spiCmdIsFast & (spiFastCode == `APS_FC_FULL_SHDN);
    assign isFullReset = cmdEvent & spiCmdIsFast & (spiFastCode == `APS_FC_FULL_RESET);
    assign isCfgWrite  = cmdEvent & ~spiCmdIsFast;

    // fast commands that select a converter mode
    always @*
    begin
        isModeCmd = 1'b0;
        cmdMode   = `APS_MODE_SHDN;
        if (cmdEvent && spiCmdIsFast)
        begin
            case (spiFastCode)
                `APS_FC_CONV:
                begin
                    isModeCmd = 1'b1;
                    cmdMode   = `APS_MODE_CONV;
                end
                `APS_FC_STBY:
                begin
                    isModeCmd = 1'b1;
                    cmdMode   = `APS_MODE_STBY;
                end
                `APS_FC_SHDN:
                begin
                    isModeCmd = 1'b1;
                    cmdMode   = `APS_MODE_SHDN;
                end
                default:
                begin
                    isModeCmd = 1'b0;
                    cmdMode   = `APS_MODE_SHDN;
                end
            endcase
        end
    end

    // mode written by this command, whether by register write or fast command
    wire       modeTouched;
    wire [1:0] newMode;

    assign modeTouched = isCfgWrite | isModeCmd;
    assign newMode     = isCfgWrite ? spiCfgData[`APS_MODE_HI:`APS_MODE_LO] : cmdMode;

    // ==========================================================
    // configuration register and full shutdown flag
    reg [`APS_CFG_WIDTH-1:0] nxt_mainConfigReg;
    reg                      nxt_fullShutdown;

    // commands are decoded in full shutdown too; the mode, monitor, bias and partial flag stay forced off
    always @*
    begin
        nxt_mainConfigReg = mainConfigReg_ff;
        nxt_fullShutdown  = fullShutdown_ff;
        if (isFullShdn)
        begin
            nxt_mainConfigReg = `APS_CFG_RESET;
            nxt_fullShutdown  = 1'b1;
        end
        else if (isFullReset)
        begin
            nxt_mainConfigReg = `APS_CFG_RESET;
            nxt_fullShutdown  = 1'b0;
        end
        else if (isCfgWrite)
        begin
            nxt_mainConfigReg = spiCfgData;
        end
        else if (isModeCmd)
        begin
            nxt_mainConfigReg[`APS_MODE_HI:`APS_MODE_LO] = cmdMode;
            if (cmdMode != mainConfigReg_ff[`APS_MODE_HI:`APS_MODE_LO])
                nxt_fullShutdown = 1'b0;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mainConfigReg_ff   <= `APS_CFG_RESET;
            fullShutdown_ff    <= 1'b0;
            fullResetPulse_ff  <= 1'b0;
        end
        else
        begin
            mainConfigReg_ff   <= nxt_mainConfigReg;
            fullShutdown_ff    <= nxt_fullShutdown;
            fullResetPulse_ff  <= isFullReset;
        end
    end

    // power controls; result register lives elsewhere and is never touched here
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            partialShutdown_ff <= 1'b0;
            supplyMonitorEn_ff <= 1'b0;
            biasEn_ff          <= 1'b0;
        end
        else
        begin
            partialShutdown_ff <= ~nxt_fullShutdown &
                (nxt_mainConfigReg[`APS_PARTIAL_HI:`APS_PARTIAL_LO] == 7'h00);
            supplyMonitorEn_ff <= ~nxt_fullShutdown;
            biasEn_ff          <= ~nxt_fullShutdown;
        end
    end

    // ==========================================================
    // divided master clock tick, halted and cleared in full shutdown
    reg [3:0] divCnt_ff;

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divCnt_ff    <= `APS_DIVIDED_MASTER_CLOCK_DIV;
            dmclkTick_ff <= 1'b0;
        end
        else if (fullShutdown_ff)
        begin
            divCnt_ff    <= `APS_DIVIDED_MASTER_CLOCK_DIV;
            dmclkTick_ff <= 1'b0;
        end
        else if (divCnt_ff == `APS_DIV_ONE)
        begin
            divCnt_ff    <= `APS_DIVIDED_MASTER_CLOCK_DIV;
            dmclkTick_ff <= 1'b1;
        end
        else
        begin
            divCnt_ff    <= divCnt_ff - `APS_DIV_ONE;
            dmclkTick_ff <= 1'b0;
        end
    end

    // ==========================================================
    // scan inter-cycle delay
    reg [23:0] scanCnt_ff;
    reg        scanHoldShdn_ff;
    reg        scanHoldStby_ff;
    wire       scanRestart;
    wire       scanStart;

    // any serial write that sets the mode, in any mode, or full shutdown restarts the scan sequence
    assign scanRestart = modeTouched | fullShutdown_ff;
    // only a converting scan may park or hold; otherwise a programmed shutdown would be overridden
    assign scanStart   = scanCycleDone & (conversionRepeatMode == `APS_SCAN_CONT) &
                         (mainConfigReg_ff[`APS_MODE_HI:`APS_MODE_LO] == `APS_MODE_CONV);

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scanCnt_ff       <= `APS_SCAN_ZERO;
            scanHoldShdn_ff  <= 1'b0;
            scanHoldStby_ff  <= 1'b0;
            scanNextCycle_ff <= 1'b0;
        end
        else if (scanRestart)
        begin
            scanCnt_ff       <= `APS_SCAN_ZERO;
            scanHoldShdn_ff  <= 1'b0;
            scanHoldStby_ff  <= 1'b0;
            scanNextCycle_ff <= 1'b0;
        end
        else if (scanStart)
        begin
            scanCnt_ff       <= scanDelay;
            scanHoldShdn_ff  <= (scanDelay > `APS_SCAN_SHDN_MIN);
            scanHoldStby_ff  <= ~(scanDelay > `APS_SCAN_SHDN_MIN);
            scanNextCycle_ff <= 1'b0;
        end
        else if ((scanHoldShdn_ff || scanHoldStby_ff) && dmclkTick_ff)
        begin
            if (scanCnt_ff == `APS_SCAN_ZERO)
            begin
                scanHoldShdn_ff  <= 1'b0;
                scanHoldStby_ff  <= 1'b0;
                scanNextCycle_ff <= 1'b1;
            end
            else
            begin
                scanCnt_ff <= scanCnt_ff - 24'h000001;
                // wake 256 ticks early so the converter is settled at expiry
                if (scanHoldShdn_ff && scanCnt_ff == `APS_SCAN_SHDN_MIN)
                begin
                    scanHoldShdn_ff <= 1'b0;
                    scanHoldStby_ff <= 1'b1;
                end
            end
        end
        else
        begin
            scanNextCycle_ff <= 1'b0;
        end
    end

    // ==========================================================
    // effective converter mode
    reg [1:0] effMode;

    always @*
    begin
        if (fullShutdown_ff || scanHoldShdn_ff)
            effMode = `APS_MODE_SHDN;
        else if (scanHoldStby_ff)
            effMode = `APS_MODE_STBY;
        else
            effMode = mainConfigReg_ff[`APS_MODE_HI:`APS_MODE_LO];
    end

    // ==========================================================
    // synchronisation delay after serial mode writes
    reg [1:0] syncCnt_ff;

    // every serial write of a 1x mode restarts the delay, even unchanged, except while full shutdown stays set
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            syncCnt_ff <= `APS_SYNC_ZERO;
        else if (nxt_fullShutdown)
            syncCnt_ff <= `APS_SYNC_ZERO;
        else if (modeTouched && newMode[`APS_MODE_HI])
            syncCnt_ff <= `APS_SYNC_CYCLES;
        else if (syncCnt_ff != `APS_SYNC_ZERO)
            syncCnt_ff <= syncCnt_ff - 2'h1;
    end

    // ==========================================================
    // converter state machine
    reg [3:0] nxt_adcState;

    always @*
    begin
        case (adcState_ff)
            `APS_ST_SHDN:
                nxt_adcState = effMode[`APS_MODE_HI] ? `APS_ST_WAKE : `APS_ST_SHDN;
            `APS_ST_WAKE:
                if (!effMode[`APS_MODE_HI])
                    nxt_adcState = `APS_ST_SHDN;
                else if (startupTimer_ff == `APS_TIMER_ZERO)
                    nxt_adcState = (effMode == `APS_MODE_CONV) ? `APS_ST_CONV
                                                               : `APS_ST_STBY;
                else
                    nxt_adcState = `APS_ST_WAKE;
            `APS_ST_STBY:
                if (!effMode[`APS_MODE_HI])
                    nxt_adcState = `APS_ST_SHDN;
                else if (effMode == `APS_MODE_CONV)
                    nxt_adcState = `APS_ST_CONV;
                else
                    nxt_adcState = `APS_ST_STBY;
            `APS_ST_CONV:
                if (!effMode[`APS_MODE_HI])
                    nxt_adcState = `APS_ST_SHDN;
                else if (effMode == `APS_MODE_STBY)
                    nxt_adcState = `APS_ST_STBY;
                else
                    nxt_adcState = `APS_ST_CONV;
            default:
                nxt_adcState = `APS_ST_SHDN;
        endcase
    end

    // ==========================================================
    // start-up timer
    reg [8:0] nxt_startupTimer;

    // the timer only moves in the wake state; the sync delay pauses it for serial writes
    always @*
    begin
        nxt_startupTimer = startupTimer_ff;
        if (fullShutdown_ff || !effMode[`APS_MODE_HI])
            nxt_startupTimer = `APS_STARTUP_CYCLES;
        else if (adcState_ff == `APS_ST_WAKE && dmclkTick_ff &&
                 syncCnt_ff == `APS_SYNC_ZERO &&
                 startupTimer_ff != `APS_TIMER_ZERO)
            nxt_startupTimer = startupTimer_ff - 9'h001;
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adcState_ff     <= `APS_ST_SHDN;
            startupTimer_ff <= `APS_STARTUP_CYCLES;
        end
        else
        begin
            adcState_ff     <= nxt_adcState;
            startupTimer_ff <= nxt_startupTimer;
        end
    end

endmodule

//--- src/aps_regs.vh
`ifndef APS_REGS_VH
`define APS_REGS_VH

// ==========================================================
// configuration register layout
`define APS_CFG_RESET       8'h00
`define APS_CFG_WIDTH       8
`define APS_MODE_HI         1
`define APS_MODE_LO         0
`define APS_MODE_CONV       2'h3
`define APS_MODE_STBY       2'h2
`define APS_MODE_SHDN       2'h0
`define APS_PARTIAL_HI      7
`define APS_PARTIAL_LO      1

// ==========================================================
// fast command codes
`define APS_FC_CONV         4'ha
`define APS_FC_STBY         4'hb
`define APS_FC_SHDN         4'hc
`define APS_FC_FULL_SHDN    4'hd
`define APS_FC_FULL_RESET   4'he

// ==========================================================
// timing counts
`define APS_STARTUP_CYCLES  9'h100
`define APS_TIMER_ZERO      9'h000
`define APS_SYNC_CYCLES     2'h2
`define APS_SYNC_ZERO       2'h0
`define APS_DIVIDED_MASTER_CLOCK_DIV       4'h4
`define APS_DIV_ONE         4'h1
`define APS_SCAN_CONT       2'h3
`define APS_SCAN_SHDN_MIN   24'h000100
`define APS_SCAN_ZERO       24'h000000

// ==========================================================
// converter states, one-hot
`define APS_ST_SHDN         4'h1
`define APS_ST_WAKE         4'h2
`define APS_ST_STBY         4'h4
`define APS_ST_CONV         4'h8

`endif

//--- src/aps_sync3.v
// ==========================================================
// three-stage synchroniser with agreement filter
module aps_sync3
(
    // clock and reset
    input  wire clk_sys,
    input  wire rst_n,
    // asynchronous level in, filtered level out
    input  wire asyncIn,
    output reg  syncOut_ff
);

    reg stage1_ff;
    reg stage2_ff;
    reg stage3_ff;

    // stage1 feeds only stage2; the output moves only when stages 2 and 3 agree
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_ff  <= 1'b0;
            stage2_ff  <= 1'b0;
            stage3_ff  <= 1'b0;
            syncOut_ff <= 1'b0;
        end
        else
        begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            if (stage2_ff == stage3_ff)
                syncOut_ff <= stage3_ff;
        end
    end

endmodule

//--- test/aps_host_model.sv
// ==========================================================
// serial host stand-in: one level toggle per command
module aps_host_model
(
    // clock
    input  wire logic       clk_sys,
    // command lines
    output logic            spiCmdToggle,
    output logic            spiCmdIsFast,
    output logic [3:0]      spiFastCode,
    output logic [7:0]      spiCfgData
);
    timeunit 1ns;
    timeprecision 1ps;

    // lines stay static between commands, which also keeps full shutdown quiet
    initial
    begin
        spiCmdToggle = 1'b0;
        spiCmdIsFast = 1'b0;
        spiFastCode  = 4'h0;
        spiCfgData   = 8'h00;
    end

    // fields settle before the toggle and hold past the answer; gap makes a slow host
    task automatic sendCmd(input logic isFast, input logic [3:0] code,
                           input logic [7:0] data, input int gap);
        @(negedge clk_sys);
        spiCmdIsFast = isFast;
        spiFastCode  = code;
        spiCfgData   = data;
        repeat (6 + gap) @(negedge clk_sys);
        spiCmdToggle = ~spiCmdToggle;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule

//--- test/aps_ps_sva.sv
// ==========================================================
// power mode and start-up timer checker
module aps_ps_sva
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // design outputs
    input  wire logic [7:0] mainConfigReg_ff,
    input  wire logic       fullShutdown_ff,
    input  wire logic       partialShutdown_ff,
    input  wire logic       supplyMonitorEn_ff,
    input  wire logic       biasEn_ff,
    input  wire logic       fullResetPulse_ff,
    input  wire logic [3:0] adcState_ff,
    input  wire logic [8:0] startupTimer_ff,
    input  wire logic       dmclkTick_ff,
    input  wire logic       scanNextCycle_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // full shutdown
    full_entry_a:
        assert property ($rose(fullShutdown_ff) |-> mainConfigReg_ff == 8'h00)
        else $error("full shutdown entered with nonzero config");
    monitor_off_a:
        assert property (fullShutdown_ff && $past(fullShutdown_ff) |->
                         !supplyMonitorEn_ff && !biasEn_ff)
        else $error("monitors alive in full shutdown");
    full_timer_a:
        assert property (fullShutdown_ff && $past(fullShutdown_ff) |->
                         startupTimer_ff == 9'h100 && !scanNextCycle_ff)
        else $error("timer running in full shutdown");
    reset_cmd_a:
        assert property (fullResetPulse_ff |-> ##[0:1] mainConfigReg_ff == 8'h00
                         && !fullShutdown_ff)
        else $error("full reset left config or shutdown set");
    partial_flag_a:
        assert property (partialShutdown_ff |->
                         mainConfigReg_ff[7:1] == 7'h00 && !fullShutdown_ff)
        else $error("partial flag with active blocks");

    // ==========================================================
    // converter state and start-up timer
    shdn_now_a:
        assert property (!mainConfigReg_ff[1] |=> adcState_ff == 4'h1)
        else $error("shutdown mode not immediate");
    shdn_reload_a:
        assert property (adcState_ff == 4'h1 |-> startupTimer_ff == 9'h100)
        else $error("timer not reloaded in shutdown");
    conv_ready_a:
        assert property (adcState_ff == 4'h8 |-> startupTimer_ff == 9'h000)
        else $error("converting before timer expired");
    timer_step_a:
        assert property (adcState_ff == 4'h2 && $past(adcState_ff) == 4'h2
                         && $changed(startupTimer_ff) |->
                         startupTimer_ff == $past(startupTimer_ff) - 9'h001)
        else $error("timer moved by other than one");
    tick_gap_a:
        assert property (dmclkTick_ff && !fullShutdown_ff |=> !dmclkTick_ff [*3])
        else $error("divided tick too frequent");
    wake_stby_a:
        assert property (adcState_ff == 4'h2 && startupTimer_ff == 9'h000 &&
                         mainConfigReg_ff[1:0] == 2'h2 |=> adcState_ff == 4'h4)
        else $error("wake did not settle in standby");

    // main scenarios
    cover property ($rose(fullShutdown_ff));
    cover property (adcState_ff == 4'h8);
    cover property (scanNextCycle_ff);
endmodule

//--- test/tb_top.sv
`include "aps_regs.vh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // stimulus
    logic        clk_sys;
    logic        rst_n;
    logic [1:0]  conversionRepeatMode;
    logic [23:0] scanDelay;
    logic        scanCycleDone;
    // host lines and design outputs
    wire         spiCmdToggle, spiCmdIsFast;
    wire  [3:0]  spiFastCode, adcState_ff;
    wire  [7:0]  spiCfgData, mainConfigReg_ff;
    wire         fullShutdown_ff, partialShutdown_ff, supplyMonitorEn_ff, biasEn_ff;
    wire         fullResetPulse_ff, dmclkTick_ff, scanNextCycle_ff;
    wire  [8:0]  startupTimer_ff;
    // bookkeeping
    int          err_count;
    int          compares;
    int          n;
    logic [31:0] rngState;
    logic [31:0] r;
    logic        sawReset, sawNext, parked;

    aps_host_model host (.clk_sys(clk_sys), .spiCmdToggle(spiCmdToggle),
        .spiCmdIsFast(spiCmdIsFast), .spiFastCode(spiFastCode), .spiCfgData(spiCfgData));

    aps_power_sequencer dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .spiCmdToggle(spiCmdToggle), .spiCmdIsFast(spiCmdIsFast),
        .spiFastCode(spiFastCode), .spiCfgData(spiCfgData),
        .conversionRepeatMode(conversionRepeatMode), .scanDelay(scanDelay),
        .scanCycleDone(scanCycleDone), .mainConfigReg_ff(mainConfigReg_ff),
        .fullShutdown_ff(fullShutdown_ff), .partialShutdown_ff(partialShutdown_ff),
        .supplyMonitorEn_ff(supplyMonitorEn_ff), .biasEn_ff(biasEn_ff),
        .fullResetPulse_ff(fullResetPulse_ff), .adcState_ff(adcState_ff),
        .startupTimer_ff(startupTimer_ff), .dmclkTick_ff(dmclkTick_ff),
        .scanNextCycle_ff(scanNextCycle_ff));

    // 125 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // one-cycle pulses are latched so a later look cannot miss them
    always @(posedge clk_sys)
    begin
        if (fullResetPulse_ff === 1'b1)
            sawReset <= 1'b1;
        if (scanNextCycle_ff === 1'b1)
            sawNext <= 1'b1;
    end

    function automatic logic [31:0] xorshift();
        rngState = rngState ^ (rngState << 13);
        rngState = rngState ^ (rngState >> 17);
        rngState = rngState ^ (rngState << 5);
        return rngState;
    endfunction

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // bounded wait for a converter state, n counts the cycles taken
    task automatic waitState(input logic [3:0] s, input int lim);
        n = 0;
        while (adcState_ff !== s && n < lim)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (adcState_ff !== s)
        begin
            err_count++;
            $display("[FAIL] state wait expected %h seen %h", s, adcState_ff);
            summarize();
        end
    endtask

    task automatic pulseDone();
        @(negedge clk_sys);
        scanCycleDone = 1'b1;
        @(negedge clk_sys);
        scanCycleDone = 1'b0;
    endtask

    initial
    begin
        rst_n = 1'b0;
        conversionRepeatMode = 2'h0;
        scanDelay = 24'h000000;
        scanCycleDone = 1'b0;
        err_count = 0;
        compares = 0;
        rngState = 32'd73660;
        sawReset = 1'b0;
        sawNext = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        check("cfg reset", 24'h00, mainConfigReg_ff);
        check("timer reset", `APS_STARTUP_CYCLES, startupTimer_ff);
        // divided clock: one tick per divider span, counted over a whole number of spans
        n = 0;
        repeat (40)
        begin
            @(negedge clk_sys);
            if (dmclkTick_ff === 1'b1)
                n++;
        end
        check("tick rate", 24'(40 / `APS_DIVIDED_MASTER_CLOCK_DIV), 24'(n));
        // cold start: 256 divided ticks plus the two-clock sync delay
        host.sendCmd(1'b1, `APS_FC_CONV, 8'h00, 0);
        waitState(`APS_ST_CONV, 1200);
        check("startup span", 24'h1, 24'(n >= 1015 && n <= 1040));
        check("conv mode", 24'h3, mainConfigReg_ff[1:0]);
        // with the timer spent, standby and conversion swap at once
        host.sendCmd(1'b1, `APS_FC_STBY, 8'h00, 0);
        check("to standby", `APS_ST_STBY, adcState_ff);
        host.sendCmd(1'b1, `APS_FC_STBY, 8'h00, 3);
        check("rewrite state", `APS_ST_STBY, adcState_ff);
        check("rewrite timer", 24'h0, startupTimer_ff);
        host.sendCmd(1'b1, `APS_FC_CONV, 8'h00, 0);
        check("to conv", `APS_ST_CONV, adcState_ff);
        // long scan delay parks the converter, wakes 256 ticks before expiry
        conversionRepeatMode = `APS_SCAN_CONT;
        scanDelay = 24'd300;
        pulseDone();
        repeat (2) @(negedge clk_sys);
        check("scan park", `APS_ST_SHDN, adcState_ff);
        waitState(`APS_ST_WAKE, 400);
        check("wake lead", 24'h1, 24'(n >= 160 && n <= 200));
        waitState(`APS_ST_CONV, 1200);
        // short delay holds standby throughout
        scanDelay = 24'd100;
        sawNext = 1'b0;
        parked = 1'b0;
        pulseDone();
        repeat (420)
        begin
            @(negedge clk_sys);
            if (adcState_ff === `APS_ST_SHDN)
                parked = 1'b1;
        end
        check("short no park", 24'h0, parked);
        check("delay expiry", 24'h1, sawNext);
        // random configuration writes, two corner values first
        conversionRepeatMode = 2'h0;
        for (int i = 0; i < 8; i++)
        begin
            r = xorshift();
            if (i < 2)
                r[7:0] = (i == 0) ? 8'h01 : 8'h00;
            host.sendCmd(1'b0, 4'h0, r[7:0], int'(r[10:8]));
            check("cfg write", r[7:0], mainConfigReg_ff);
            check("no full entry", 24'h0, fullShutdown_ff);
            check("partial flag", 24'(r[7:1] == 7'h00), partialShutdown_ff);
            if (r[1] == 1'b0)
                check("shdn state", `APS_ST_SHDN, adcState_ff);
        end
        // full shutdown from standby with other fields set
        host.sendCmd(1'b0, 4'h0, 8'h5e, 0);
        waitState(`APS_ST_STBY, 1200);
        host.sendCmd(1'b1, `APS_FC_FULL_SHDN, 8'h00, 0);
        check("full entry", 24'h1, fullShutdown_ff);
        check("cfg forced", 24'h00, mainConfigReg_ff);
        check("monitor off", 24'h0, supplyMonitorEn_ff);
        check("bias off", 24'h0, biasEn_ff);
        check("timer halted", `APS_STARTUP_CYCLES, startupTimer_ff);
        host.sendCmd(1'b0, 4'h0, 8'h32, 2);
        check("write taken", 24'h32, mainConfigReg_ff);
        check("write no exit", 24'h1, fullShutdown_ff);
        // recovery; key and interrupt writes go to registers outside this block
        host.sendCmd(1'b1, `APS_FC_FULL_RESET, 8'h00, 0);
        check("reset pulse", 24'h1, sawReset);
        check("reset cfg", 24'h00, mainConfigReg_ff);
        check("reset exit", 24'h0, fullShutdown_ff);
        // a mode-changing fast command also leaves full shutdown
        host.sendCmd(1'b1, `APS_FC_FULL_SHDN, 8'h00, 0);
        host.sendCmd(1'b1, `APS_FC_STBY, 8'h00, 1);
        check("fast exit", 24'h0, fullShutdown_ff);
        check("exit mode", 24'h2, mainConfigReg_ff[1:0]);
        summarize();
    end
endmodule

bind aps_power_sequencer aps_ps_sva chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .mainConfigReg_ff(mainConfigReg_ff), .fullShutdown_ff(fullShutdown_ff),
    .partialShutdown_ff(partialShutdown_ff), .supplyMonitorEn_ff(supplyMonitorEn_ff),
    .biasEn_ff(biasEn_ff), .fullResetPulse_ff(fullResetPulse_ff),
    .adcState_ff(adcState_ff), .startupTimer_ff(startupTimer_ff),
    .dmclkTick_ff(dmclkTick_ff), .scanNextCycle_ff(scanNextCycle_ff));
